// *** core/irc_defines.svh ***
// Contract
// - reset pin high, held 5 ms minimum
// - pin low again releases the cpu
// - selected key pins high together reset
// - build option picks key pin pattern
// - optional time test before key reset
// - watchdog runaway asserts initial reset
// - oscillator absent or stopped holds reset
// - reset loads step 00h, page 1h
// - reset clears interrupt enable flag
// - interrupt vectors at page 1, 01h-0fh
// - unserviced watchdog resets within 3-4 s
// - 3-bit watchdog on 2 hz, msb overflow
`ifndef IRC_DEFINES_SVH
`define IRC_DEFINES_SVH

// clock rates
`define IRC_PCLK_HZ          125000000
`define IRC_PCLK_MHZ         (`IRC_PCLK_HZ / 1000000)
`define IRC_OSC_HZ           32768

// noise rejection, least time, rounded up to whole oscillator ticks
`define IRC_RST_MIN_MS       5
`define IRC_RST_MIN_TICKS    ((`IRC_RST_MIN_MS * `IRC_OSC_HZ + 999) / 1000)

// time test within 1..3 s
`define IRC_TIME_TEST_MS     2000
`define IRC_TIME_TEST_TICKS  (`IRC_TIME_TEST_MS * `IRC_OSC_HZ / 1000)

// watchdog timebase
`define IRC_TB_HZ            2
`define IRC_TB_DIV_TICKS     (`IRC_OSC_HZ / `IRC_TB_HZ)

// oscillator detector: longest gap between edges, rounded down
`define IRC_OSC_FAIL_US      120
`define IRC_OSC_FAIL_CYC     (`IRC_OSC_FAIL_US * `IRC_PCLK_MHZ)
`define IRC_OSC_START_EDGES  4

// cpu reset values and vector window
`define IRC_PC_STEP_RST      8'h00
`define IRC_PC_PAGE_RST      4'h1
`define IRC_NEXT_PAGE_RST    4'h1
`define IRC_IE_RST           1'h0
`define IRC_VEC_FIRST        8'h01
`define IRC_VEC_LAST         8'h0F

// register map
`define IRC_ADDR_CTRL        8'h00
`define IRC_ADDR_STAT        8'h04
`define IRC_ADDR_CFG         8'h08
`define IRC_CTRL_WD_RESTART  0
`define IRC_STAT_CAUSE_LSB   0
`define IRC_STAT_WD_LSB      4
`define IRC_STAT_OSC_OK      7
`define IRC_STAT_CPU_RST     8
`define IRC_CFG_KEYSEL_LSB   0
`define IRC_CFG_TTEST        2
`define IRC_CFG_WDT_EN       3

`endif

// *** core/irc_pkg.sv ***
package irc_pkg;

    typedef struct packed {
        logic [7:0] pc_step;
        logic [3:0] pc_page;
        logic [3:0] next_page_pointer;
        logic       int_enable;
    } irc_cpu_init_t;

    typedef struct packed {
        logic osc_fail;
        logic watchdog;
        logic key_combo;
        logic ext_pin;
    } irc_cause_t;

    typedef enum logic [1:0] {
        IRC_KEYS_OFF  = 2'b00,
        IRC_KEYS_01   = 2'b01,
        IRC_KEYS_012  = 2'b10,
        IRC_KEYS_0123 = 2'b11
    } irc_key_sel_t;

    typedef enum logic [1:0] {
        IRC_OSC_DEAD     = 2'b00,
        IRC_OSC_STARTING = 2'b01,
        IRC_OSC_RUNNING  = 2'b10
    } irc_osc_state_t;

endpackage

// *** core/irc_noise_filter.sv ***
`timescale 1ns/1ps
module irc_noise_filter #(
    parameter int COUNT = 164
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // oscillator tick and level to qualify
    input  wire logic tick,
    input  wire logic level,
    // qualified level
    output logic      qual_r
);
    localparam int CW = $clog2(COUNT + 1);

    if (COUNT < 1) begin : g_bad_count
        $error("irc_noise_filter: COUNT must be at least 1");
    end

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    wire           full = (cnt_r == CW'(COUNT));

    // any low sample restarts the count, so short pulses never qualify
    assign cnt_nxt = !level ? '0 : (tick && !full) ? cnt_r + CW'(1) : cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r  <= '0;
            qual_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            qual_r <= level && full;
        end
    end
endmodule

// *** core/irc_watchdog.sv ***
`timescale 1ns/1ps
module irc_watchdog (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // control
    input  wire logic       enable,
    input  wire logic       restart,
    input  wire logic       tick_2hz,
    // state
    output logic [2:0]      count_r,
    output logic            overflow_r
);
    logic [2:0] count_nxt;
    wire        wrap = enable && tick_2hz && (count_r == 3'h7);

    // restart wins over a tick in the same cycle
    assign count_nxt = (restart || !enable) ? 3'h0 :
                       tick_2hz ? count_r + 3'h1 : count_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r    <= 3'h0;
            overflow_r <= 1'b0;
        end else begin
            count_r    <= count_nxt;
            overflow_r <= wrap && !restart;
        end
    end
endmodule

// *** core/irc_top.sv ***
`timescale 1ns/1ps
`include "irc_defines.svh"
module irc_top #(
    parameter int KEY_SEL         = 3,
    parameter bit TIME_TEST_EN    = 1'b0,
    parameter bit WDT_EN          = 1'b1,
    parameter int TIME_TEST_TICKS = `IRC_TIME_TEST_TICKS,
    parameter int TB_DIV_TICKS    = `IRC_TB_DIV_TICKS,
    parameter int OSC_FAIL_CYC    = `IRC_OSC_FAIL_CYC
) (
    // apb clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // pins
    input  wire logic                  reset_pin,
    input  wire logic [3:0]            key_input_pins,
    input  wire logic                  main_crystal_osc,
    // interrupt vector request from the cpu
    input  wire logic [3:0]            irq_vec_idx,
    // cpu side
    output logic                       cpu_reset,
    output irc_pkg::irc_cpu_init_t     cpu_init,
    output logic [3:0]                 vec_page,
    output logic [7:0]                 vec_step
);
    if (KEY_SEL < 0 || KEY_SEL > 3) begin : g_bad_key_sel
        $error("irc_top: KEY_SEL must be 0..3");
    end
    if (TB_DIV_TICKS < 2 || OSC_FAIL_CYC < 2 || TIME_TEST_TICKS < 1) begin : g_bad_counts
        $error("irc_top: timing parameters too small");
    end

    localparam int TBW = $clog2(TB_DIV_TICKS);
    localparam int OFW = $clog2(OSC_FAIL_CYC + 1);
    localparam int SEW = $clog2(`IRC_OSC_START_EDGES + 1);

    localparam irc_pkg::irc_key_sel_t KEY_MODE = irc_pkg::irc_key_sel_t'(KEY_SEL);

    // key pattern mask per build option
    function automatic logic [3:0] key_mask(input irc_pkg::irc_key_sel_t sel);
        unique case (sel)
            irc_pkg::IRC_KEYS_OFF:  key_mask = 4'h0;
            irc_pkg::IRC_KEYS_01:   key_mask = 4'h3;
            irc_pkg::IRC_KEYS_012:  key_mask = 4'h7;
            irc_pkg::IRC_KEYS_0123: key_mask = 4'hF;
        endcase
    endfunction

    // register address decode
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] reg_addr);
        addr_is = (a == reg_addr);
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers: stage one is read only by stage two
    // ------------------------------------------------------------------
    logic [5:0] pin_meta_r;
    logic [5:0] pin_sync_r;
    logic       osc_prev_r;
    wire  [5:0] pin_raw = {main_crystal_osc, key_input_pins, reset_pin};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_r <= 6'h00;
            pin_sync_r <= 6'h00;
            osc_prev_r <= 1'b0;
        end else begin
            pin_meta_r <= pin_raw;
            pin_sync_r <= pin_meta_r;
            osc_prev_r <= pin_sync_r[5];
        end
    end

    wire       rst_pin_s = pin_sync_r[0];
    wire [3:0] keys_s    = pin_sync_r[4:1];
    wire       osc_s     = pin_sync_r[5];
    wire       osc_tick  = osc_s && !osc_prev_r;

    // ------------------------------------------------------------------
    // oscillation detector
    // ------------------------------------------------------------------
    irc_pkg::irc_osc_state_t osc_state_r;
    irc_pkg::irc_osc_state_t osc_state_nxt;
    logic [OFW-1:0]          gap_cnt_r;
    logic [SEW-1:0]          edge_cnt_r;
    logic                    osc_ok_r;

    wire gap_expired = (gap_cnt_r == OFW'(OSC_FAIL_CYC));
    wire start_done  = (edge_cnt_r == SEW'(`IRC_OSC_START_EDGES));

    always_comb begin
        osc_state_nxt = osc_state_r;
        unique case (osc_state_r)
            irc_pkg::IRC_OSC_DEAD: begin
                if (osc_tick) begin
                    osc_state_nxt = irc_pkg::IRC_OSC_STARTING;
                end
            end
            irc_pkg::IRC_OSC_STARTING: begin
                if (gap_expired) begin
                    osc_state_nxt = irc_pkg::IRC_OSC_DEAD;
                end else if (start_done) begin
                    osc_state_nxt = irc_pkg::IRC_OSC_RUNNING;
                end
            end
            irc_pkg::IRC_OSC_RUNNING: begin
                if (gap_expired) begin
                    osc_state_nxt = irc_pkg::IRC_OSC_DEAD;
                end
            end
            default: osc_state_nxt = irc_pkg::IRC_OSC_DEAD;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_state_r <= irc_pkg::IRC_OSC_DEAD;
            gap_cnt_r   <= '0;
            edge_cnt_r  <= '0;
            osc_ok_r    <= 1'b0;
        end else begin
            osc_state_r <= osc_state_nxt;
            gap_cnt_r   <= (osc_tick || gap_expired) ? '0 : gap_cnt_r + OFW'(1);
            if (osc_state_nxt != irc_pkg::IRC_OSC_STARTING) begin
                edge_cnt_r <= '0;
            end else if (osc_tick && !start_done) begin
                edge_cnt_r <= edge_cnt_r + SEW'(1);
            end
            // held low from power-on until the crystal runs
            osc_ok_r <= (osc_state_nxt == irc_pkg::IRC_OSC_RUNNING);
        end
    end

    // ------------------------------------------------------------------
    // 2 hz timebase from oscillator ticks
    // ------------------------------------------------------------------
    logic [TBW-1:0] tb_cnt_r;
    logic           tick_2hz_r;
    wire            tb_last = (tb_cnt_r == TBW'(TB_DIV_TICKS - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tb_cnt_r   <= '0;
            tick_2hz_r <= 1'b0;
        end else begin
            if (osc_tick) begin
                tb_cnt_r <= tb_last ? '0 : tb_cnt_r + TBW'(1);
            end
            tick_2hz_r <= osc_tick && tb_last;
        end
    end

    // ------------------------------------------------------------------
    // reset pin and key pattern noise rejection
    // ------------------------------------------------------------------
    logic ext_q;
    logic key_nf_q;
    logic key_q;

    wire [3:0] sel_mask = key_mask(KEY_MODE);
    wire       keys_all = (sel_mask != 4'h0) && (&(keys_s | ~sel_mask));

    irc_noise_filter #(
        .COUNT (`IRC_RST_MIN_TICKS)
    ) u_ext_filter (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (osc_tick),
        .level   (rst_pin_s),
        .qual_r  (ext_q)
    );

    irc_noise_filter #(
        .COUNT (`IRC_RST_MIN_TICKS)
    ) u_key_filter (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (osc_tick),
        .level   (keys_all),
        .qual_r  (key_nf_q)
    );

    if (TIME_TEST_EN) begin : g_time_test
        // a second, long qualifier guards against accidental key chords
        irc_noise_filter #(
            .COUNT (TIME_TEST_TICKS)
        ) u_time_test (
            .pclk    (pclk),
            .presetn (presetn),
            .tick    (osc_tick),
            .level   (key_nf_q),
            .qual_r  (key_q)
        );
    end else begin : g_no_time_test
        assign key_q = key_nf_q;
    end

    // ------------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------------
    logic [2:0] wd_count;
    logic       wd_overflow;
    logic       wd_hold_r;
    logic       wd_kick;
    logic       cpu_reset_r;

    irc_watchdog u_watchdog (
        .pclk       (pclk),
        .presetn    (presetn),
        .enable     (WDT_EN),
        .restart    (wd_kick || cpu_reset_r),
        .tick_2hz   (tick_2hz_r),
        .count_r    (wd_count),
        .overflow_r (wd_overflow)
    );

    // stretch the overflow pulse to one oscillator period so the cpu sees it;
    // a new overflow wins over the release tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_hold_r <= 1'b0;
        end else if (wd_overflow) begin
            wd_hold_r <= 1'b1;
        end else if (osc_tick) begin
            wd_hold_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // combined reset and cpu initial values
    // ------------------------------------------------------------------
    irc_pkg::irc_cause_t    cause_now;
    irc_pkg::irc_cpu_init_t init_val;
    irc_pkg::irc_cpu_init_t cpu_init_r;
    logic [7:0]             vec_step_r;
    logic [3:0]             vec_page_r;

    assign cause_now.ext_pin   = ext_q;
    assign cause_now.key_combo = key_q;
    assign cause_now.watchdog  = wd_hold_r;
    assign cause_now.osc_fail  = !osc_ok_r;

    // pin release drops the reset once filtered level goes low
    wire reset_any = |cause_now;

    assign init_val.pc_step           = `IRC_PC_STEP_RST;
    assign init_val.pc_page           = `IRC_PC_PAGE_RST;
    assign init_val.next_page_pointer = `IRC_NEXT_PAGE_RST;
    assign init_val.int_enable        = `IRC_IE_RST;

    // vector index 0 is the reset entry; it maps to the first vector step
    wire [7:0] vec_idx_step = {4'h0, irq_vec_idx};
    wire [7:0] vec_sel = (vec_idx_step < `IRC_VEC_FIRST) ? `IRC_VEC_FIRST :
                         (vec_idx_step > `IRC_VEC_LAST)  ? `IRC_VEC_LAST  : vec_idx_step;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_reset_r <= 1'b1;
            cpu_init_r  <= '{pc_step: `IRC_PC_STEP_RST, pc_page: `IRC_PC_PAGE_RST,
                             next_page_pointer: `IRC_NEXT_PAGE_RST, int_enable: `IRC_IE_RST};
            vec_page_r  <= `IRC_PC_PAGE_RST;
            vec_step_r  <= `IRC_VEC_FIRST;
        end else begin
            cpu_reset_r <= reset_any;
            cpu_init_r  <= init_val;
            vec_page_r  <= `IRC_PC_PAGE_RST;
            vec_step_r  <= vec_sel;
        end
    end

    // ------------------------------------------------------------------
    // apb slave: one wait-free access phase, answer prepared in setup
    // ------------------------------------------------------------------
    irc_pkg::irc_cause_t cause_r;
    irc_pkg::irc_cause_t cause_prev_r;
    logic                pready_r;
    logic                pslverr_r;
    logic [31:0]         prdata_r;

    wire setup    = psel && !penable;
    wire wr_done  = psel && penable && pready_r && pwrite;
    wire hit_ctrl = addr_is(paddr, `IRC_ADDR_CTRL);
    wire hit_stat = addr_is(paddr, `IRC_ADDR_STAT);
    wire hit_cfg  = addr_is(paddr, `IRC_ADDR_CFG);
    wire mapped   = hit_ctrl || hit_stat || hit_cfg;

    assign wd_kick = wr_done && hit_ctrl && pstrb[0] && pwdata[`IRC_CTRL_WD_RESTART];

    wire [3:0] cause_rise = cause_now & ~cause_prev_r;
    wire [3:0] cause_clr  = (wr_done && hit_stat && pstrb[0]) ?
                            pwdata[`IRC_STAT_CAUSE_LSB +: 4] : 4'h0;

    wire [31:0] stat_word = {23'h000000, cpu_reset_r, osc_ok_r, wd_count, cause_r};
    wire [31:0] cfg_word  = {28'h0000000, WDT_EN, TIME_TEST_EN, KEY_MODE};
    wire [31:0] rd_word   = hit_stat ? stat_word : hit_cfg ? cfg_word : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_r      <= '0;
            cause_prev_r <= '0;
        end else begin
            cause_prev_r <= cause_now;
            // a new event wins over a software clear in the same cycle
            cause_r      <= (cause_r & ~cause_clr) | cause_rise;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup && !mapped;
            prdata_r  <= (setup && !pwrite) ? rd_word : 32'h00000000;
        end
    end

    assign pready    = pready_r;
    assign pslverr   = pslverr_r;
    assign prdata    = prdata_r;
    assign cpu_reset = cpu_reset_r;
    assign cpu_init  = cpu_init_r;
    assign vec_page  = vec_page_r;
    assign vec_step  = vec_step_r;

endmodule

// *** bench/irc_props.sv ***
`timescale 1ns/1ps
module irc_props #(
    parameter int OSC_FAIL_CYC = 15000
) (
    // clock and reset
    input wire logic                   pclk,
    input wire logic                   presetn,
    // apb
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic [7:0]             paddr,
    input wire logic                   pready,
    input wire logic [31:0]            prdata,
    input wire logic                   pslverr,
    // pins
    input wire logic                   reset_pin,
    input wire logic                   main_crystal_osc,
    // cpu side
    input wire logic [3:0]             irq_vec_idx,
    input wire logic                   cpu_reset,
    input wire irc_pkg::irc_cpu_init_t cpu_init,
    input wire logic [3:0]             vec_page,
    input wire logic [7:0]             vec_step
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic        osc_d_r;
    logic [15:0] gap_r;
    logic [15:0] gap_nxt;
    logic [8:0]  pin_ticks_r;
    logic [8:0]  pin_ticks_nxt;
    wire         osc_rise = main_crystal_osc & ~osc_d_r;

    // raw pins are watched, so margins cover the design's synchroniser lag
    assign gap_nxt = (main_crystal_osc != osc_d_r) ? 16'h0000 :
                     (gap_r == 16'hFFFF) ? gap_r : gap_r + 16'h0001;
    assign pin_ticks_nxt = !reset_pin ? 9'h000 :
                           (osc_rise && pin_ticks_r != 9'h1FF) ? pin_ticks_r + 9'h001 : pin_ticks_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_d_r     <= 1'b0;
            gap_r       <= 16'h0000;
            pin_ticks_r <= 9'h000;
        end else begin
            osc_d_r     <= main_crystal_osc;
            gap_r       <= gap_nxt;
            pin_ticks_r <= pin_ticks_nxt;
        end
    end

    pc_entry_a: assert property (
        cpu_init.pc_step == 8'h00 && cpu_init.pc_page == 4'h1 && cpu_init.next_page_pointer == 4'h1)
        else $error("reset entry point wrong");
    int_flag_a: assert property (cpu_init.int_enable == 1'b0)
        else $error("interrupt flag not cleared");
    vec_page_a: assert property (vec_page == 4'h1)
        else $error("vector page wrong");
    vec_step_a: assert property ($past(presetn) |->
        vec_step == (($past(irq_vec_idx) == 4'h0) ? 8'h01 : {4'h0, $past(irq_vec_idx)}))
        else $error("vector step wrong");
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    unmapped_err_a: assert property (psel && !penable && paddr > 8'h08 |=> pready && pslverr)
        else $error("unmapped access not refused");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    osc_dead_a: assert property (int'(gap_r) > OSC_FAIL_CYC + 8 |-> cpu_reset)
        else $error("stopped oscillator without reset");
    pin_long_a: assert property (pin_ticks_r >= 9'h0A6 |-> cpu_reset)
        else $error("long reset pin ignored");
endmodule

bind irc_top irc_props #(.OSC_FAIL_CYC(OSC_FAIL_CYC)) u_irc_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .reset_pin(reset_pin),
    .main_crystal_osc(main_crystal_osc), .irq_vec_idx(irq_vec_idx), .cpu_reset(cpu_reset),
    .cpu_init(cpu_init), .vec_page(vec_page), .vec_step(vec_step)
);

// *** bench/irc_board_model.sv ***
`timescale 1ns/1ps
module irc_board_model (
    // clock
    input wire logic        pclk,
    // requests
    input wire logic        osc_run,
    input wire logic        pin_req,
    input wire logic [3:0]  key_req,
    // board pins
    output logic            main_crystal_osc,
    output logic            reset_pin,
    output logic [3:0]      key_input_pins
);
    logic [4:0] div_r;

    initial begin
        div_r = 5'h00;
        main_crystal_osc = 1'b0;
        reset_pin = 1'b0;
        key_input_pins = 4'h0;
    end

    // crystal period is 40 pclk; it freezes when stopped, as a dead crystal would
    always @(posedge pclk) begin
        reset_pin <= pin_req;
        key_input_pins <= key_req;
        if (osc_run) begin
            div_r <= (div_r == 5'h13) ? 5'h00 : div_r + 5'h01;
            if (div_r == 5'h13) begin
                main_crystal_osc <= ~main_crystal_osc;
            end
        end
    end
endmodule

// *** bench/initial_reset_controller_bench.sv ***
`timescale 1ns/1ps
module initial_reset_controller_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic [3:0]  irq_vec_idx = 4'h0;
    logic        osc_run = 1'b0;
    logic        pin_req = 1'b0;
    logic [3:0]  key_req = 4'h0;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        main_crystal_osc;
    logic        reset_pin;
    logic [3:0]  key_input_pins;
    logic        cpu_reset;
    logic [3:0]  vec_page;
    logic [7:0]  vec_step;
    logic [31:0] rd_q;
    logic        err_q;
    int          bad_count = 0;
    int          samples_checked = 0;
    irc_pkg::irc_cpu_init_t cpu_init;

    always #4 pclk = ~pclk;

    irc_top #(.TB_DIV_TICKS(64), .TIME_TEST_TICKS(8), .OSC_FAIL_CYC(100)) u_irc_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .reset_pin(reset_pin), .key_input_pins(key_input_pins),
        .main_crystal_osc(main_crystal_osc), .irq_vec_idx(irq_vec_idx),
        .cpu_reset(cpu_reset), .cpu_init(cpu_init), .vec_page(vec_page), .vec_step(vec_step)
    );

    irc_board_model u_irc_board_model (
        .pclk(pclk), .osc_run(osc_run), .pin_req(pin_req), .key_req(key_req),
        .main_crystal_osc(main_crystal_osc), .reset_pin(reset_pin),
        .key_input_pins(key_input_pins)
    );

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_rst(input logic v, input int n);
        int i;
        i = 0;
        while (cpu_reset !== v && i < n) begin
            @(posedge pclk);
            i++;
        end
        chk("cpu_reset", {31'h0, v}, {31'h0, cpu_reset});
    endtask

    task automatic ticks(input int n);
        repeat (n * 40) @(posedge pclk);
    endtask

    // reads the sticky causes, then clears them all
    task automatic cause(input logic [3:0] exp);
        apb(1'b0, 8'h04, 32'h0);
        chk("cause", {28'h0, exp}, {28'h0, rd_q[3:0]});
        apb(1'b1, 8'h04, 32'h0000000F);
    endtask

    initial begin
        repeat (90000) @(posedge pclk);
        bad_count++;
        print_verdict();
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (300) @(posedge pclk);
        chk("no osc", 32'h1, {31'h0, cpu_reset});
        osc_run <= 1'b1;
        wait_rst(1'b0, 400);
        chk("cpu_init", 32'h00000022, {15'h0, cpu_init});
        for (int k = 0; k < 16; k++) begin
            irq_vec_idx <= k[3:0];
            repeat (2) @(posedge pclk);
            chk("vector", {20'h0, 4'h1, ((k == 0) ? 8'h01 : k[7:0])}, {20'h0, vec_page, vec_step});
        end
        apb(1'b0, 8'h08, 32'h0);
        chk("cfg", 32'h0000000B, rd_q);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err_q});
        chk("unmapped data", 32'h0, rd_q);
        apb(1'b1, 8'h04, 32'h0000000F);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b0, 8'h04, 32'h0);
        chk("stat", 32'h00000080, rd_q);
        // power-on style reset comes from the pin, not the auxiliary sources
        pin_req <= 1'b1;
        ticks(100);
        chk("short pin", 32'h0, {31'h0, cpu_reset});
        pin_req <= 1'b0;
        ticks(2);
        apb(1'b1, 8'h00, 32'h1);
        pin_req <= 1'b1;
        ticks(170);
        chk("long pin", 32'h1, {31'h0, cpu_reset});
        pin_req <= 1'b0;
        wait_rst(1'b0, 20);
        cause(4'h1);
        apb(1'b1, 8'h00, 32'h1);
        key_req <= 4'h7;
        ticks(170);
        chk("partial keys", 32'h0, {31'h0, cpu_reset});
        key_req <= 4'hF;
        ticks(170);
        chk("all keys", 32'h1, {31'h0, cpu_reset});
        key_req <= 4'h0;
        wait_rst(1'b0, 20);
        cause(4'h2);
        apb(1'b1, 8'h00, 32'h1);
        ticks(440);
        chk("wd early", 32'h0, {31'h0, cpu_reset});
        wait_rst(1'b1, 4000);
        wait_rst(1'b0, 200);
        cause(4'h4);
        osc_run <= 1'b0;
        wait_rst(1'b1, 200);
        osc_run <= 1'b1;
        wait_rst(1'b0, 400);
        cause(4'h8);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("reset hold", 32'h1, {31'h0, cpu_reset});
        presetn <= 1'b1;
        wait_rst(1'b0, 600);
        print_verdict();
    end
endmodule
